// ===== logic/pmc_pkg.sv
// Purpose: shared constants and types for the power mode and clock select block
// Assumes: special function register bus with 8-bit data and 8-bit address
// Notes: oscillators are seen as one-cycle ticks synchronous to the core clock
package pmc_pkg;

  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_CLOCK_SOURCE_SELECT = 8'ha9;
  localparam logic [7:0] ADDR_HF_OSC_CONTROL = 8'hb2;
  localparam logic [7:0] ADDR_HF_OSC_TRIM = 8'hb3;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int PC_IDLE_BIT = 0;
  localparam int PC_STOP_BIT = 1;
  localparam int PC_GF_LSB = 2;
  localparam int PC_GF_MSB = 7;
  localparam int HC_HF_DIVIDER_FIELD_LSB = 0;
  localparam int HC_HF_DIVIDER_FIELD_MSB = 1;
  localparam int HC_STSYNC_BIT = 4;
  localparam int HC_SUSPEND_BIT = 5;
  localparam int HC_READY_BIT = 6;
  localparam int HC_ENABLE_BIT = 7;
  localparam int TRIM_MSB = 6;
  localparam logic [5:0] GF_RESET = 6'h00;
  localparam logic [1:0] SRC_RESET = 2'h0;
  localparam logic [1:0] HF_DIVIDER_FIELD_RESET = 2'h0;
  localparam logic HF_ENABLE_RESET = 1'b1;
  localparam logic [6:0] TRIM_RESET = 7'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ****************************************
  // system clock sources and divider codes
  // ****************************************
  localparam logic [1:0] SRC_HF = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_LF = 2'h2;
  localparam logic [1:0] SRC_RSVD = 2'h3;
  localparam logic [1:0] DIV_BY8 = 2'h0;
  localparam logic [1:0] DIV_BY4 = 2'h1;
  localparam logic [1:0] DIV_BY2 = 2'h2;
  localparam logic [1:0] DIV_BY1 = 2'h3;
  localparam logic [2:0] DIV_CNT_RESET = 3'h0;

  // crystal settling wait that software observes before polling valid
  localparam int XTAL_WAIT_MS = 1;
  localparam int CLK_MHZ = 100;

  // ****************************************
  // power modes, gray along run-idle-suspend-stop
  // ****************************************
  typedef enum logic [1:0] {
    PM_RUN = 2'h0,
    PM_IDLE = 2'h1,
    PM_SUSPEND = 2'h3,
    PM_STOP = 2'h2
  } pmc_mode_t;

endpackage : pmc_pkg

// ===== logic/pmc_hf_divider.sv
// Purpose: post divider of the high-frequency oscillator tick
// Assumes: hf_tick is a one-cycle pulse per oscillator period
// Notes: output tick is registered
`timescale 1ns/1ps
module pmc_hf_divider (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hf_tick,
  input wire logic [1:0] div_sel,
  output logic div_tick
);

  logic [2:0] cnt_ff;
  logic div_tick_ff;

  // ****************************************
  // terminal count per divider code
  // ****************************************
  function automatic logic [2:0] last_count(input logic [1:0] sel);
    case (sel)
      pmc_pkg::DIV_BY8: last_count = 3'h7;
      pmc_pkg::DIV_BY4: last_count = 3'h3;
      pmc_pkg::DIV_BY2: last_count = 3'h1;
      default: last_count = 3'h0;
    endcase
  endfunction : last_count

  // a code change mid-count ends the period early rather than late
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= pmc_pkg::DIV_CNT_RESET;
      div_tick_ff <= 1'b0;
    end else if (hf_tick) begin
      if (cnt_ff >= last_count(div_sel)) begin
        cnt_ff <= pmc_pkg::DIV_CNT_RESET;
        div_tick_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 3'h1;
        div_tick_ff <= 1'b0;
      end
    end else begin
      div_tick_ff <= 1'b0;
    end
  end

  assign div_tick = div_tick_ff;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);

  by_eight_a: assert property ((div_sel == pmc_pkg::DIV_BY8 && cnt_ff == 3'h7 && hf_tick) |=> div_tick)
    else $error("divide by eight tick missing");
  by_one_a: assert property ((div_sel == pmc_pkg::DIV_BY1 && hf_tick) |=> div_tick)
    else $error("divide by one did not pass tick");

endmodule : pmc_hf_divider

// ===== logic/pmc_clk_mux.sv
// Purpose: system clock source selection between three ticks
// Assumes: ticks are one-cycle pulses synchronous to clk
// Notes: a switch completes at a period boundary of the old source, or at once when leaving a stopped hf source
`timescale 1ns/1ps
module pmc_clk_mux (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [1:0] src_sel,
  input wire logic tick_hf,
  input wire logic tick_ext,
  input wire logic tick_lf,
  input wire logic hf_running,
  output logic sys_tick,
  output logic [1:0] cur_src
);

  logic [1:0] cur_ff;
  logic sys_tick_ff;
  logic cur_tick;
  logic pend;
  logic cur_dead;

  function automatic logic pick(input logic [1:0] s, input logic h, input logic e, input logic l);
    case (s)
      pmc_pkg::SRC_HF: pick = h;
      pmc_pkg::SRC_EXT: pick = e;
      pmc_pkg::SRC_LF: pick = l;
      default: pick = 1'b0;
    endcase
  endfunction : pick

  assign cur_tick = pick(cur_ff, tick_hf, tick_ext, tick_lf);
  // reserved code keeps the running source
  assign pend = (src_sel != cur_ff) && (src_sel != pmc_pkg::SRC_RSVD);
  // a stopped hf source has no boundary left to wait for
  assign cur_dead = (cur_ff == pmc_pkg::SRC_HF) && !hf_running;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cur_ff <= pmc_pkg::SRC_RESET;
    end else if (pend && (cur_tick || cur_dead)) begin
      cur_ff <= src_sel;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_tick_ff <= 1'b0;
    end else begin
      sys_tick_ff <= cur_tick;
    end
  end

  assign sys_tick = sys_tick_ff;
  assign cur_src = cur_ff;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);

  switch_boundary_a: assert property ($changed(cur_ff) |-> $past(cur_tick) || $past(cur_dead))
    else $error("source switched inside a period");
  rsvd_hold_a: assert property ((src_sel == pmc_pkg::SRC_RSVD) |=> $stable(cur_ff))
    else $error("reserved code changed source");

endmodule : pmc_clk_mux

// ===== logic/pmc_top.sv
// Purpose: power modes, system clock select, hf post divider, suspend and trim
// Assumes: registers are reached over the core special function register bus
// Notes: oscillators and timers live outside; this block gates clock enables
`timescale 1ns/1ps
module pmc_top (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  input wire logic INSTR_DONE,
  input wire logic INT_PENDING,
  input wire logic P0_MATCH,
  input wire logic P1_MATCH,
  input wire logic CMP0_EN,
  input wire logic CMP0_OUT,
  input wire logic T3_OVF,
  input wire logic HF_OSC_TICK,
  input wire logic EXT_OSC_TICK,
  input wire logic LF_OSC_TICK,
  input wire logic HF_READY,
  input wire logic XTAL_SETTLED,
  input wire logic [6:0] TRIM_FACTORY,
  output logic SYSTEM_CLOCK_TICK,
  output logic CPU_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic HF_OSC_RUN,
  output logic [6:0] HF_TRIM,
  output logic EXT_TIMER_TICK,
  output logic CRYSTAL_VALID,
  output pmc_pkg::pmc_mode_t POWER_MODE
);

  // ****************************************
  // register bus decode
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction : hit

  logic wr_pc;
  logic wr_cs;
  logic wr_hc;
  logic wr_trim;
  logic wr_idle;
  logic wr_stop;
  logic wr_susp;

  assign wr_pc = SFR_WR && hit(SFR_ADDR, pmc_pkg::ADDR_POWER_CONTROL);
  assign wr_cs = SFR_WR && hit(SFR_ADDR, pmc_pkg::ADDR_CLOCK_SOURCE_SELECT);
  assign wr_hc = SFR_WR && hit(SFR_ADDR, pmc_pkg::ADDR_HF_OSC_CONTROL);
  assign wr_trim = SFR_WR && hit(SFR_ADDR, pmc_pkg::ADDR_HF_OSC_TRIM);
  assign wr_idle = wr_pc && SFR_WDATA[pmc_pkg::PC_IDLE_BIT];
  assign wr_stop = wr_pc && SFR_WDATA[pmc_pkg::PC_STOP_BIT];
  assign wr_susp = wr_hc && SFR_WDATA[pmc_pkg::HC_SUSPEND_BIT];

  // ****************************************
  // software registers
  // ****************************************
  logic [5:0] general_flags_ff;
  logic [1:0] system_clock_source_field_ff;
  logic [1:0] hf_divider_field_ff;
  logic hf_enable_ff;
  logic suspend_bit_ff;
  logic [6:0] hf_osc_trim_ff;
  logic trim_loaded_ff;
  logic wake;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      general_flags_ff <= pmc_pkg::GF_RESET;
    end else if (wr_pc) begin
      general_flags_ff <= SFR_WDATA[pmc_pkg::PC_GF_MSB:pmc_pkg::PC_GF_LSB];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      system_clock_source_field_ff <= pmc_pkg::SRC_RESET;
    end else if (wr_cs) begin
      system_clock_source_field_ff <= SFR_WDATA[1:0];
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      hf_divider_field_ff <= pmc_pkg::HF_DIVIDER_FIELD_RESET;
      hf_enable_ff <= pmc_pkg::HF_ENABLE_RESET;
    end else if (wr_hc) begin
      hf_divider_field_ff <= SFR_WDATA[pmc_pkg::HC_HF_DIVIDER_FIELD_MSB:pmc_pkg::HC_HF_DIVIDER_FIELD_LSB];
      hf_enable_ff <= SFR_WDATA[pmc_pkg::HC_ENABLE_BIT];
    end
  end

  // a software set in the wake cycle wins over the hardware clear
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      suspend_bit_ff <= 1'b0;
    end else if (wr_hc) begin
      suspend_bit_ff <= SFR_WDATA[pmc_pkg::HC_SUSPEND_BIT];
    end else if (wake && POWER_MODE == pmc_pkg::PM_SUSPEND) begin
      suspend_bit_ff <= 1'b0;
    end
  end

  // factory value is a level, so it is caught on the first edge after release
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      hf_osc_trim_ff <= pmc_pkg::TRIM_RESET;
      trim_loaded_ff <= 1'b0;
    end else if (!trim_loaded_ff) begin
      hf_osc_trim_ff <= TRIM_FACTORY;
      trim_loaded_ff <= 1'b1;
    end else if (wr_trim) begin
      hf_osc_trim_ff <= SFR_WDATA[pmc_pkg::TRIM_MSB:0];
    end
  end

  // ****************************************
  // read port
  // ****************************************
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;

  always_comb begin
    nxt_rdata = pmc_pkg::READ_ZERO;
    case (SFR_ADDR)
      pmc_pkg::ADDR_POWER_CONTROL: begin
        // mode select bits always read back as zero
        nxt_rdata[pmc_pkg::PC_GF_MSB:pmc_pkg::PC_GF_LSB] = general_flags_ff;
      end
      pmc_pkg::ADDR_CLOCK_SOURCE_SELECT: begin
        nxt_rdata[1:0] = system_clock_source_field_ff;
      end
      pmc_pkg::ADDR_HF_OSC_CONTROL: begin
        nxt_rdata[pmc_pkg::HC_ENABLE_BIT] = hf_enable_ff;
        nxt_rdata[pmc_pkg::HC_READY_BIT] = HF_READY;
        nxt_rdata[pmc_pkg::HC_SUSPEND_BIT] = suspend_bit_ff;
        nxt_rdata[pmc_pkg::HC_HF_DIVIDER_FIELD_MSB:pmc_pkg::HC_HF_DIVIDER_FIELD_LSB] = hf_divider_field_ff;
      end
      pmc_pkg::ADDR_HF_OSC_TRIM: begin
        nxt_rdata[pmc_pkg::TRIM_MSB:0] = hf_osc_trim_ff;
      end
      default: begin
        nxt_rdata = pmc_pkg::READ_ZERO;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_ff <= pmc_pkg::READ_ZERO;
    end else if (SFR_RD) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // power mode sequencing
  // ****************************************
  pmc_pkg::pmc_mode_t mode_ff;
  pmc_pkg::pmc_mode_t nxt_mode;
  logic pend_idle_ff;
  logic pend_stop_ff;
  logic req_idle;
  logic req_stop;
  logic req_susp;

  // a request written in the finishing cycle belongs to that instruction
  assign req_idle = pend_idle_ff || wr_idle;
  assign req_stop = pend_stop_ff || wr_stop;
  assign req_susp = (suspend_bit_ff && !wr_hc) || wr_susp;
  assign wake = P0_MATCH || P1_MATCH || (CMP0_EN && !CMP0_OUT) || T3_OVF;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pend_idle_ff <= 1'b0;
      pend_stop_ff <= 1'b0;
    end else if (INSTR_DONE || mode_ff != pmc_pkg::PM_RUN) begin
      pend_idle_ff <= 1'b0;
      pend_stop_ff <= 1'b0;
    end else begin
      pend_idle_ff <= req_idle;
      pend_stop_ff <= req_stop;
    end
  end

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      pmc_pkg::PM_RUN: begin
        if (INSTR_DONE) begin
          if (req_stop) begin
            nxt_mode = pmc_pkg::PM_STOP;
          end else if (req_susp) begin
            nxt_mode = pmc_pkg::PM_SUSPEND;
          end else if (req_idle) begin
            nxt_mode = pmc_pkg::PM_IDLE;
          end
        end
      end
      pmc_pkg::PM_IDLE: begin
        if (INT_PENDING) begin
          nxt_mode = pmc_pkg::PM_RUN;
        end
      end
      pmc_pkg::PM_SUSPEND: begin
        if (wake) begin
          nxt_mode = pmc_pkg::PM_RUN;
        end
      end
      pmc_pkg::PM_STOP: begin
        nxt_mode = pmc_pkg::PM_STOP;
      end
      default: begin
        nxt_mode = pmc_pkg::PM_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode_ff <= pmc_pkg::PM_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // ****************************************
  // clock path
  // ****************************************
  logic hf_running;
  logic hf_div_tick;
  logic mux_tick;
  logic [1:0] cur_src;
  logic on_hf;

  assign hf_running = hf_enable_ff && mode_ff != pmc_pkg::PM_STOP && mode_ff != pmc_pkg::PM_SUSPEND;
  assign on_hf = (cur_src == pmc_pkg::SRC_HF);

  pmc_hf_divider u_div (
    .clk(CLK),
    .rstn(RSTN),
    .hf_tick(HF_OSC_TICK && hf_running),
    .div_sel(hf_divider_field_ff),
    .div_tick(hf_div_tick)
  );

  // switching to an unsettled source is left to software
  pmc_clk_mux u_mux (
    .clk(CLK),
    .rstn(RSTN),
    .src_sel(system_clock_source_field_ff),
    .tick_hf(hf_div_tick),
    .tick_ext(EXT_OSC_TICK),
    .tick_lf(LF_OSC_TICK),
    .hf_running(hf_running),
    .sys_tick(mux_tick),
    .cur_src(cur_src)
  );

  logic system_clock_tick_ff;
  logic cpu_en_ff;
  logic periph_en_ff;
  logic hf_run_ff;
  logic ext_tick_ff;
  logic xtal_valid_ff;
  logic susp_gate;

  assign susp_gate = (mode_ff == pmc_pkg::PM_SUSPEND) && on_hf;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      system_clock_tick_ff <= 1'b0;
      cpu_en_ff <= 1'b0;
      periph_en_ff <= 1'b0;
    end else begin
      system_clock_tick_ff <= mux_tick && mode_ff != pmc_pkg::PM_STOP;
      cpu_en_ff <= mux_tick && (mode_ff == pmc_pkg::PM_RUN || (mode_ff == pmc_pkg::PM_SUSPEND && !on_hf));
      periph_en_ff <= mux_tick && mode_ff != pmc_pkg::PM_STOP && !susp_gate;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      hf_run_ff <= 1'b0;
    end else begin
      hf_run_ff <= hf_running;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ext_tick_ff <= 1'b0;
    end else begin
      ext_tick_ff <= EXT_OSC_TICK;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      xtal_valid_ff <= 1'b0;
    end else begin
      xtal_valid_ff <= XTAL_SETTLED;
    end
  end

  assign SFR_RDATA = rdata_ff;
  assign SYSTEM_CLOCK_TICK = system_clock_tick_ff;
  assign CPU_CLK_EN = cpu_en_ff;
  assign PERIPH_CLK_EN = periph_en_ff;
  assign HF_OSC_RUN = hf_run_ff;
  assign HF_TRIM = hf_osc_trim_ff;
  assign EXT_TIMER_TICK = ext_tick_ff;
  assign CRYSTAL_VALID = xtal_valid_ff;
  assign POWER_MODE = mode_ff;

  // ****************************************
  // checks
  // ****************************************
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence idle_asked;
    mode_ff == pmc_pkg::PM_RUN && pend_idle_ff && !req_stop && !req_susp;
  endsequence
  sequence suspend_woken;
    mode_ff == pmc_pkg::PM_SUSPEND ##0 wake;
  endsequence

  idle_entry_a: assert property (idle_asked ##0 INSTR_DONE |=> mode_ff == pmc_pkg::PM_IDLE)
    else $error("idle not entered at instruction end");
  idle_exit_a: assert property (mode_ff == pmc_pkg::PM_IDLE && INT_PENDING |=> mode_ff == pmc_pkg::PM_RUN)
    else $error("interrupt did not end idle");
  stop_hold_a: assert property (mode_ff == pmc_pkg::PM_STOP |=> mode_ff == pmc_pkg::PM_STOP [*2])
    else $error("stop left without reset");
  stop_read_a: assert property (SFR_RD && SFR_ADDR == pmc_pkg::ADDR_POWER_CONTROL |=> !SFR_RDATA[1])
    else $error("stop bit read as one");
  cpu_gate_a: assert property (mode_ff == pmc_pkg::PM_IDLE |=> !CPU_CLK_EN)
    else $error("cpu clock ran in idle");
  clock_source_select_upper_a: assert property (SFR_RD && SFR_ADDR == pmc_pkg::ADDR_CLOCK_SOURCE_SELECT
    |=> SFR_RDATA[7:2] == 6'h00)
    else $error("clock select upper bits not zero");
  wake_resume_a: assert property (suspend_woken |=> mode_ff == pmc_pkg::PM_RUN ##1 HF_OSC_RUN == hf_enable_ff)
    else $error("wake did not resume oscillator");
  flags_store_a: assert property (wr_pc |=> general_flags_ff == $past(SFR_WDATA[7:2]))
    else $error("general flags not stored");
  trim_top_a: assert property (SFR_RD && SFR_ADDR == pmc_pkg::ADDR_HF_OSC_TRIM |=> !SFR_RDATA[7])
    else $error("trim bit 7 read as one");
  xtal_valid_a: assert property ($rose(XTAL_SETTLED) |=> CRYSTAL_VALID)
    else $error("crystal valid not raised");
  ext_tick_a: assert property (EXT_OSC_TICK |=> EXT_TIMER_TICK)
    else $error("external tick lost for timers");

endmodule : pmc_top

// ===== bench/pmc_top_test.sv
// Purpose: self-checking bench for the power mode and clock select block
// Assumes: oscillator ticks are made here, synchronous to the core clock
// Notes: inputs change on the rising edge by non-blocking assignment
`timescale 1ns/1ps
module pmc_top_test;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clk, rstn, sfr_wr, sfr_rd, instr_done, int_pending, xtal;
  logic p0_match, p1_match, cmp0_en, cmp0_out, t3_ovf, hf_on, hf_t, ext_t, lf_t;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_val;
  logic [6:0] hf_trim;
  logic sys_tick, cpu_en, per_en, hf_run, ext_tmr, xtal_ok;
  pmc_pkg::pmc_mode_t mode;
  int failures, num_checks, cyc, n_sys, n_cpu, n_per, n_ext;
  int ocnt = 0;
  int expv [4] = '{20, 16, 16, 80};
  logic [1:0] order [4] = '{2'h1, 2'h2, 2'h3, 2'h0};

  pmc_top dut_u (
    .CLK(clk), .RSTN(rstn), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd),
    .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .INSTR_DONE(instr_done),
    .INT_PENDING(int_pending), .P0_MATCH(p0_match), .P1_MATCH(p1_match),
    .CMP0_EN(cmp0_en), .CMP0_OUT(cmp0_out), .T3_OVF(t3_ovf), .HF_OSC_TICK(hf_t),
    .EXT_OSC_TICK(ext_t), .LF_OSC_TICK(lf_t), .HF_READY(1'b1), .XTAL_SETTLED(xtal),
    .TRIM_FACTORY(7'h55), .SYSTEM_CLOCK_TICK(sys_tick), .CPU_CLK_EN(cpu_en),
    .PERIPH_CLK_EN(per_en), .HF_OSC_RUN(hf_run), .HF_TRIM(hf_trim),
    .EXT_TIMER_TICK(ext_tmr), .CRYSTAL_VALID(xtal_ok), .POWER_MODE(mode)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ext period 4 and lf period 5 keep the expected tick counts distinct
  always @(posedge clk) begin
    ocnt <= ocnt + 1;
    hf_t <= hf_on;
    ext_t <= (ocnt % 4 == 0);
    lf_t <= (ocnt % 5 == 0);
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk_n(input int got, input int exp, input string what);
    num_checks++;
    if (got != exp) begin
      failures++;
      $display("mismatch at %0t: %s count %0d expected %0d", $time, what, got, exp);
    end
  endtask : chk_n

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(posedge clk);
    #1;
    v = sfr_rdata;
  endtask : sfr_read

  task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr_read(a, rd_val);
    chk8(rd_val, exp, "register read");
  endtask : read_chk

  task automatic finish_instr();
    @(posedge clk);
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
    @(posedge clk);
    #1;
  endtask : finish_instr

  task automatic count(input int n);
    n_sys = 0;
    n_cpu = 0;
    n_per = 0;
    n_ext = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      n_sys += (sys_tick === 1'b1);
      n_cpu += (cpu_en === 1'b1);
      n_per += (per_en === 1'b1);
      n_ext += (ext_tmr === 1'b1);
    end
  endtask : count

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // first access only at the second edge, after the factory trim load
    repeat (2) @(posedge clk);
    #1;
  endtask : do_reset

  task automatic chk_mode(input pmc_pkg::pmc_mode_t m);
    chk8({6'h00, mode}, {6'h00, m}, "power mode");
  endtask : chk_mode

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    chk8({7'h00, hf_run}, 8'h01, "hf run");
    chk8({1'b0, hf_trim}, 8'h55, "factory trim");
    chk8({7'h00, xtal_ok}, 8'h00, "crystal valid");
    read_chk(pmc_pkg::ADDR_POWER_CONTROL, 8'h00);
    read_chk(pmc_pkg::ADDR_CLOCK_SOURCE_SELECT, 8'h00);
    read_chk(pmc_pkg::ADDR_HF_OSC_CONTROL, 8'hc0);
    read_chk(pmc_pkg::ADDR_HF_OSC_TRIM, 8'h55);
    read_chk(8'h00, 8'h00);
  endtask : test_reset

  task automatic test_regs();
    sfr_write(pmc_pkg::ADDR_POWER_CONTROL, 8'hfc);
    read_chk(pmc_pkg::ADDR_POWER_CONTROL, 8'hfc);
    sfr_write(pmc_pkg::ADDR_CLOCK_SOURCE_SELECT, 8'hff);
    read_chk(pmc_pkg::ADDR_CLOCK_SOURCE_SELECT, 8'h03);
    sfr_write(pmc_pkg::ADDR_CLOCK_SOURCE_SELECT, 8'h00);
    sfr_write(pmc_pkg::ADDR_HF_OSC_TRIM, 8'hff);
    read_chk(pmc_pkg::ADDR_HF_OSC_TRIM, 8'h7f);
    chk8({1'b0, hf_trim}, 8'h7f, "trim out");
    sfr_write(pmc_pkg::ADDR_HF_OSC_TRIM, 8'h00);
    read_chk(pmc_pkg::ADDR_HF_OSC_TRIM, 8'h00);
    sfr_write(8'h88, 8'hff);
    read_chk(pmc_pkg::ADDR_POWER_CONTROL, 8'hfc);
    sfr_write(pmc_pkg::ADDR_POWER_CONTROL, 8'h00);
  endtask : test_regs

  task automatic test_div();
    for (int c = 0; c < 4; c++) begin
      sfr_write(pmc_pkg::ADDR_HF_OSC_CONTROL, 8'h80 | 8'(c));
      count(12);
      count(80);
      chk_n(n_sys, 80 / (8 >> c), "divided ticks");
      chk_n(n_cpu, 80 / (8 >> c), "cpu ticks in run");
      chk_n(n_ext, 20, "ext timer ticks");
    end
  endtask : test_div

  task automatic test_src();
    // hf off first: leaving a dead source must not wait for a tick
    sfr_write(pmc_pkg::ADDR_HF_OSC_CONTROL, 8'h03);
    count(2);
    chk8({7'h00, hf_run}, 8'h00, "hf run off");
    for (int i = 0; i < 4; i++) begin
      if (order[i] == pmc_pkg::SRC_HF) begin
        sfr_write(pmc_pkg::ADDR_HF_OSC_CONTROL, 8'h83);
      end
      sfr_write(pmc_pkg::ADDR_CLOCK_SOURCE_SELECT, {6'h00, order[i]});
      count(16);
      count(80);
      chk_n(n_sys, expv[i], "source ticks");
    end
    @(posedge clk);
    xtal <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    // settle wait shortened to keep the run short; level is already up here
    chk8({7'h00, xtal_ok}, 8'h01, "crystal valid");
  endtask : test_src

  task automatic test_idle();
    sfr_write(pmc_pkg::ADDR_POWER_CONTROL, 8'h01);
    #1;
    chk_mode(pmc_pkg::PM_RUN);
    finish_instr();
    chk_mode(pmc_pkg::PM_IDLE);
    count(16);
    chk_n(n_cpu, 0, "cpu ticks in idle");
    chk_n(n_per, 16, "peripheral ticks in idle");
    read_chk(pmc_pkg::ADDR_POWER_CONTROL, 8'h00);
    @(posedge clk);
    int_pending <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_mode(pmc_pkg::PM_RUN);
    @(posedge clk);
    int_pending <= 1'b0;
  endtask : test_idle

  task automatic test_susp();
    for (int ev = 0; ev < 4; ev++) begin
      sfr_write(pmc_pkg::ADDR_HF_OSC_CONTROL, 8'ha3);
      finish_instr();
      chk_mode(pmc_pkg::PM_SUSPEND);
      count(8);
      chk_n(n_cpu + n_per, 0, "ticks in suspend");
      chk8({7'h00, hf_run}, 8'h00, "hf run in suspend");
      @(posedge clk);
      case (ev)
        0: p0_match <= 1'b1;
        1: p1_match <= 1'b1;
        2: begin
          cmp0_en <= 1'b1;
          cmp0_out <= 1'b0;
        end
        default: t3_ovf <= 1'b1;
      endcase
      @(posedge clk);
      {p0_match, p1_match, cmp0_en, t3_ovf} <= 4'h0;
      cmp0_out <= 1'b1;
      @(posedge clk);
      #1;
      chk_mode(pmc_pkg::PM_RUN);
      read_chk(pmc_pkg::ADDR_HF_OSC_CONTROL, 8'hc3);
    end
  endtask : test_susp

  task automatic test_stop();
    sfr_write(pmc_pkg::ADDR_POWER_CONTROL, 8'h06);
    finish_instr();
    chk_mode(pmc_pkg::PM_STOP);
    count(16);
    chk_n(n_sys + n_cpu, 0, "ticks in stop");
    chk8({7'h00, hf_run}, 8'h00, "hf run in stop");
    @(posedge clk);
    int_pending <= 1'b1;
    p0_match <= 1'b1;
    @(posedge clk);
    int_pending <= 1'b0;
    p0_match <= 1'b0;
    count(4);
    chk_mode(pmc_pkg::PM_STOP);
    @(posedge clk);
    do_reset();
    chk_mode(pmc_pkg::PM_RUN);
    read_chk(pmc_pkg::ADDR_POWER_CONTROL, 8'h00);
  endtask : test_stop

  task automatic give_verdict();
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  initial begin
    rstn = 1'b0;
    {sfr_wr, sfr_rd, instr_done, int_pending, xtal} = 5'h00;
    {p0_match, p1_match, cmp0_en, t3_ovf} = 4'h0;
    cmp0_out = 1'b1;
    hf_on = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    failures = 0;
    num_checks = 0;
    cyc = 0;
    do_reset();
    test_reset();
    test_regs();
    test_div();
    test_src();
    test_idle();
    test_susp();
    test_stop();
    give_verdict();
  end
endmodule : pmc_top_test
